// ==== adc_ctl_defs.svh ====
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

// Register byte offsets on the register bus.
`define OFS_STATUS_CONTROL 4'h0
`define OFS_RESULT_HIGH    4'h4
`define OFS_RESULT_LOW     4'h8
`define OFS_CLOCK_CONFIG   4'hc

// Field positions in converter_status_control.
`define SCR_FLAG_BIT  7
`define SCR_IRQEN_BIT 6
`define SCR_CONT_BIT  5

// Field positions in converter_clock_config.
`define CLK_DIV_MSB   7
`define CLK_DIV_LSB   5
`define CLK_SRC_BIT   4
`define CLK_MODE_MSB  3
`define CLK_MODE_LSB  2

// Reset values.
`define SCR_RESET     8'h1f
`define CLKCFG_RESET  8'h04

// Channel code that powers the converter off.
`define CH_POWER_OFF  5'h1f

// Converter clock cycles taken by one conversion.
`define CONV_CYCLES   5'h11

// Bus response codes.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ==== adc_ctl_pkg.sv ====
package adc_ctl_pkg;

	// Conversion sequencer states, Gray coded.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01
	} conv_state_t;

	// Result justification formats.
	typedef enum logic [1:0] {
		JUST_TRUNC  = 2'b00,
		JUST_RIGHT  = 2'b01,
		JUST_LEFT   = 2'b10,
		JUST_SIGNED = 2'b11
	} justify_t;

	// Writable part of converter_status_control.
	typedef struct packed {
		logic       irq_enable;
		logic       continuous;
		logic [4:0] channel;
	} scr_t;

	// Contents of converter_clock_config.
	typedef struct packed {
		logic [2:0] prescale;
		logic       bus_source;
		justify_t   justify;
	} clk_cfg_t;

endpackage : adc_ctl_pkg

// ==== adc_control_result_regs.sv ====
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "adc_ctl_defs.svh"
// How it works
// R1: Flag sets per conversion, cleared by result read.
// R2: Interrupt mode: flag never set, reads zero.
// R3: Software writes zero to flag position.
// R4: Interrupt raised per conversion, dropped on read/write.
// R5: Continuous repeats; otherwise one per control write.
// R6: Five-bit channel code, 24 external channels.
// R7: Codes route upper and lower references.
// R8: All-ones channel code powers converter off.
// R9: Discard first result after leaving power off.
// R10: Unused channel codes give undefined results.
// R11: Left format: top eight high, two low.
// R12: High read freezes low; new results dropped.
// R13: Right format: two high, eight low.
// R14: Signed left format inverts top result bit.
// R15: Truncation: eight bits low, high zero.
// R16: Prescaler divides by 1, 2, 4, 8, 16.
// R17: Software aims converter clock near 1 MHz.
// R18: Justify codes trunc, right, left, signed.
// R19: Clock source bit picks bus or oscillator.
// R20: Control write starts conversion of 17 clocks.
// R21: Prescaler makes a one-cycle clock enable.
module adc_control_result_regs (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// AXI4-Lite write channels.
	input  wire logic [31:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// AXI4-Lite read channels.
	input  wire logic [31:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Converter core side.
	input  wire logic        i_osc_tick,
	input  wire logic [9:0]  i_sample_result,
	output logic             o_conv_clk_en,
	output logic             o_sample_start,
	output logic [4:0]       o_channel,
	output logic             o_power_off,
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Maps a byte address to a register index; bit 2 flags a valid address.
	function automatic logic [2:0] reg_index(input logic [31:0] addr);
		logic [2:0] idx;
		idx = 3'h0;
		if (addr[31:4] == 28'h0000000 && addr[1:0] == 2'h0) begin
			idx = {1'b1, addr[3:2]};
		end
		return idx;
	endfunction : reg_index

	// Prescaler terminal count for each divide code.
	function automatic logic [3:0] div_limit(input logic [2:0] sel);
		logic [3:0] lim;
		lim = 4'hf; // [R16]
		case (sel)
			3'b000:  lim = 4'h0;
			3'b001:  lim = 4'h1;
			3'b010:  lim = 4'h3;
			3'b011:  lim = 4'h7;
			default: lim = 4'hf;
		endcase
		return lim;
	endfunction : div_limit

	// Register indices with the valid bit set, in the form that reg_index returns.
	localparam logic [2:0] IDX_SC = {1'b1, 2'(`OFS_STATUS_CONTROL >> 2)};
	localparam logic [2:0] IDX_RH = {1'b1, 2'(`OFS_RESULT_HIGH >> 2)};
	localparam logic [2:0] IDX_RL = {1'b1, 2'(`OFS_RESULT_LOW >> 2)};
	localparam logic [2:0] IDX_CK = {1'b1, 2'(`OFS_CLOCK_CONFIG >> 2)};

	////////////////////////////////////////////////////////////////////////////
	// State.

	adc_ctl_pkg::scr_t        scr_q, scr_d;
	adc_ctl_pkg::clk_cfg_t    cfg_q, cfg_d;
	adc_ctl_pkg::conv_state_t state_q, state_d;
	logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
	logic        wlane_q, wlane_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [3:0]  pre_q, pre_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        cen_q, cen_d, start_q, start_d, off_q, off_d;
	logic [9:0]  raw_q, raw_d;
	logic        lock_q, lock_d, flag_q, flag_d, irq_q, irq_d;
	logic        scr_wr, rd_hi, rd_lo, done;
	logic [2:0]  wr_idx, rd_idx;
	logic        src_tick;

	assign o_awready      = awready_q;
	assign o_wready       = wready_q;
	assign o_bvalid       = bvalid_q;
	assign o_bresp        = bresp_q;
	assign o_arready      = arready_q;
	assign o_rvalid       = rvalid_q;
	assign o_rresp        = rresp_q;
	assign o_rdata        = rdata_q;
	assign o_conv_clk_en  = cen_q;
	assign o_sample_start = start_q;
	assign o_channel      = scr_q.channel; // [R6] [R7] [R10]
	assign o_power_off    = off_q;
	assign o_irq          = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave: address and data taken in either order.

	assign wr_idx = reg_index(awaddr_q);
	assign rd_idx = reg_index(i_araddr);
	assign scr_wr = aw_held_q && w_held_q && !bvalid_q && wlane_q &&
	                wr_idx == IDX_SC;
	assign rd_hi  = i_arvalid && arready_q && rd_idx == IDX_RH;
	assign rd_lo  = i_arvalid && arready_q && rd_idx == IDX_RL;

	// Computes the bus channel state and the register writes.
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wlane_d   = wlane_q;
		bvalid_d  = bvalid_q && !i_bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q && !i_rready;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		scr_d     = scr_q;
		cfg_d     = cfg_q;
		if (i_awvalid && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d  = i_awaddr;
		end
		if (i_wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d  = i_wdata;
			wlane_d  = i_wstrb[0];
		end
		if (aw_held_q && w_held_q && !bvalid_q) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_idx[2] ? `RESP_OKAY : `RESP_SLVERR;
			// Flag position is ignored on writes. [R3]
			if (scr_wr) begin
				scr_d = wdata_q[6:0];
			end
			if (wlane_q && wr_idx == IDX_CK) begin
				cfg_d = wdata_q[7:2];
			end
		end
		if (i_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = rd_idx[2] ? `RESP_OKAY : `RESP_SLVERR;
			rdata_d  = 32'h00000000;
			case (rd_idx)
				IDX_SC: begin
					// Flag reads zero in interrupt mode. [R1] [R2]
					rdata_d[7:0] = {flag_q && !scr_q.irq_enable, scr_q};
				end
				IDX_RH: begin
					case (cfg_q.justify)
						adc_ctl_pkg::JUST_TRUNC:  rdata_d[7:0] = 8'h00; // [R15]
						adc_ctl_pkg::JUST_RIGHT:  rdata_d[7:0] = {6'h00, raw_q[9:8]}; // [R13]
						adc_ctl_pkg::JUST_LEFT:   rdata_d[7:0] = raw_q[9:2]; // [R11]
						default:                  rdata_d[7:0] = {~raw_q[9], raw_q[8:2]}; // [R14]
					endcase
				end
				IDX_RL: begin
					case (cfg_q.justify) // [R18]
						adc_ctl_pkg::JUST_TRUNC: rdata_d[7:0] = raw_q[9:2]; // [R15]
						adc_ctl_pkg::JUST_RIGHT: rdata_d[7:0] = raw_q[7:0]; // [R13]
						default:                 rdata_d[7:0] = {raw_q[1:0], 6'h00}; // [R11] [R14]
					endcase
				end
				IDX_CK: begin
					rdata_d[7:0] = {cfg_q, 2'h0};
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d  = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// Registers the bus channel state.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 32'h00000000;
			wdata_q   <= 32'h00000000;
			wlane_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= `RESP_OKAY;
			rdata_q   <= 32'h00000000;
			scr_q     <= 7'(`SCR_RESET);
			cfg_q     <= 6'(`CLKCFG_RESET >> 2); // [R18] [R19]
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wlane_q   <= wlane_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			scr_q     <= scr_d;
			cfg_q     <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and conversion sequencer.

	// Bus source ticks every cycle; the oscillator arrives as a tick input.
	assign src_tick = cfg_q.bus_source ? 1'b1 : i_osc_tick; // [R19]
	assign done     = state_q == adc_ctl_pkg::ST_CONV && cen_q && cnt_q == `CONV_CYCLES - 5'h01;

	// Computes prescaler, conversion count and start pulses.
	always_comb begin
		pre_d   = pre_q;
		cen_d   = 1'b0;
		cnt_d   = cnt_q;
		state_d = state_q;
		start_d = 1'b0;
		off_d   = scr_d.channel == `CH_POWER_OFF; // [R8]
		if (src_tick) begin
			if (pre_q >= div_limit(cfg_q.prescale)) begin
				pre_d = 4'h0;
				cen_d = 1'b1; // [R21]
			end else begin
				pre_d = pre_q + 4'h1;
			end
		end
		case (state_q)
			adc_ctl_pkg::ST_CONV: begin
				if (cen_q) begin
					cnt_d = cnt_q + 5'h01; // [R20]
				end
				if (done) begin
					cnt_d   = 5'h00;
					start_d = scr_q.continuous;
					state_d = scr_q.continuous ? adc_ctl_pkg::ST_CONV : adc_ctl_pkg::ST_IDLE; // [R5]
				end
			end
			default: begin
				state_d = adc_ctl_pkg::ST_IDLE;
			end
		endcase
		// A control write aborts any conversion and starts afresh, except with the power-off channel code. [R20] [R5]
		if (scr_wr) begin
			cnt_d   = 5'h00;
			start_d = !off_d;
			state_d = off_d ? adc_ctl_pkg::ST_IDLE : adc_ctl_pkg::ST_CONV;
		end
	end

	// Registers the prescaler and sequencer.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pre_q   <= 4'h0;
			cen_q   <= 1'b0;
			cnt_q   <= 5'h00;
			state_q <= adc_ctl_pkg::ST_IDLE;
			start_q <= 1'b0;
			off_q   <= 1'b1;
		end else begin
			pre_q   <= pre_d;
			cen_q   <= cen_d;
			cnt_q   <= cnt_d;
			state_q <= state_d;
			start_q <= start_d;
			off_q   <= off_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result capture, interlock, flag and interrupt.

	// Computes result, interlock, completion flag and interrupt request.
	always_comb begin
		raw_d  = raw_q;
		lock_d = lock_q;
		flag_d = flag_q;
		irq_d  = irq_q;
		if (done && !lock_q) begin
			raw_d = i_sample_result; // [R12]
		end
		if (rd_hi && cfg_q.justify != adc_ctl_pkg::JUST_TRUNC) begin
			lock_d = 1'b1; // [R12]
		end else if (rd_lo || cfg_q.justify == adc_ctl_pkg::JUST_TRUNC) begin
			lock_d = 1'b0; // [R15]
		end
		// Set wins over a clear in the same cycle.
		if (done && !scr_q.irq_enable) begin
			flag_d = 1'b1; // [R1]
		end else if (rd_hi || rd_lo) begin
			flag_d = 1'b0; // [R1]
		end
		if (done && scr_q.irq_enable) begin
			irq_d = 1'b1; // [R4]
		end else if (rd_hi || rd_lo || scr_wr) begin
			irq_d = 1'b0; // [R4]
		end
	end

	// Registers result, interlock, flag and interrupt.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			raw_q  <= 10'h000;
			lock_q <= 1'b0;
			flag_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			raw_q  <= raw_d;
			lock_q <= lock_d;
			flag_q <= flag_d;
			irq_q  <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	// One idle converter clock between enables.
	sequence seq_gap_one;
		!cen_q ##1 cen_q;
	endsequence

	chk_flag_set: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
		done && !scr_q.irq_enable |=> flag_q) else $error("flag not set after conversion");
	chk_flag_quiet: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
		scr_q.irq_enable && !flag_q |=> !flag_q) else $error("flag set in interrupt mode");
	chk_irq_raise: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
		done && scr_q.irq_enable |=> o_irq) else $error("interrupt not raised");
	chk_irq_drop: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
		o_irq && !done && (rd_lo || scr_wr) |=> !o_irq) else $error("interrupt not dropped");
	chk_cont_restart: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
		done && scr_q.continuous && !scr_wr |=> state_q == adc_ctl_pkg::ST_CONV && o_sample_start)
		else $error("continuous mode did not restart");
	chk_single_stop: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
		done && !scr_q.continuous && !scr_wr |=> state_q == adc_ctl_pkg::ST_IDLE)
		else $error("single mode did not stop");
	chk_power_off: assert property (@(posedge i_clk) disable iff (i_reset) // [R8]
		o_power_off == (scr_q.channel == `CH_POWER_OFF)) else $error("power off mismatch");
	chk_lock_hold: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
		lock_q && !rd_lo |=> $stable(raw_q)) else $error("locked result changed");
	chk_div_two: assert property (@(posedge i_clk) disable iff (i_reset) // [R16]
		(cfg_q.bus_source && cfg_q.prescale == 3'b001 && cen_q) ##1 $stable(cfg_q) |-> seq_gap_one)
		else $error("divide by two period wrong");

endmodule : adc_control_result_regs

// ==== adc_core_model.sv ====
`timescale 1ns/100ps
// Converter core model: holds one sample for a whole conversion.
module adc_core_model (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// Block side.
	input  wire logic       i_sample_start,
	input  wire logic       i_conv_clk_en,
	input  wire logic [4:0] i_channel,
	input  wire logic       i_power_off,
	input  wire logic [9:0] i_value,
	output logic      [9:0] o_sample_result
);
	logic       busy_q;
	logic [4:0] cnt_q;
	logic [9:0] held_q;
	logic [9:0] junk_q;
	// Outside a conversion the result lines change every cycle.
	always_ff @(posedge i_clk) begin
		junk_q <= i_reset ? 10'h000 : junk_q + 10'h137;
		if (i_reset || i_power_off) begin
			busy_q <= 1'b0;
		end else if (i_sample_start) begin
			busy_q <= 1'b1;
			cnt_q  <= 5'h00;
			held_q <= (i_channel == 5'h1d) ? 10'h3ff : (i_channel == 5'h1e) ? 10'h000 : i_value;
		end else if (busy_q && i_conv_clk_en) begin
			cnt_q  <= cnt_q + 5'h01;
			busy_q <= (cnt_q != 5'h11);
		end
	end
	// Held sample only while converting.
	assign o_sample_result = busy_q ? held_q : junk_q;
endmodule : adc_core_model

// ==== adc_control_result_regs_bench.sv ====
`timescale 1ns/100ps
`include "adc_ctl_defs.svh"
// Self-checking bench for the converter register block.
module adc_control_result_regs_bench;
	localparam logic [31:0] A_SC = {28'h0, `OFS_STATUS_CONTROL};
	localparam logic [31:0] A_RH = {28'h0, `OFS_RESULT_HIGH};
	localparam logic [31:0] A_RL = {28'h0, `OFS_RESULT_LOW};
	localparam logic [31:0] A_CK = {28'h0, `OFS_CLOCK_CONFIG};
	logic        clk, rst, osc_tick, cen, start, poff, irq;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, osc_cnt;
	logic [3:0]  wstrb;
	logic [4:0]  chan;
	logic [9:0]  value, res;
	logic [1:0]  bq[$];
	logic [34:0] rq[$];
	int          miscompares, total_checks, seed;

	adc_control_result_regs u_adc_control_result_regs (.i_clk(clk), .i_reset(rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_osc_tick(osc_tick), .i_sample_result(res),
		.o_conv_clk_en(cen), .o_sample_start(start), .o_channel(chan),
		.o_power_off(poff), .o_irq(irq));
	adc_core_model u_adc_core_model (.i_clk(clk), .i_reset(rst), .i_sample_start(start),
		.i_conv_clk_en(cen), .i_channel(chan), .i_power_off(poff), .i_value(value),
		.o_sample_result(res));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and an oscillator tick every third cycle.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rst) begin
			osc_cnt  <= 2'h0;
			osc_tick <= 1'b0;
		end else begin
			osc_cnt  <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
			osc_tick <= (osc_cnt == 2'h2);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare tasks and the closing report.
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: word %h wanted %h", $time, g, e);
		end
	endtask : chk_w
	task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: response %h wanted %h", $time, g, e);
		end
	endtask : chk_r
	task automatic chk_b(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: level %b wanted %b", $time, g, e);
		end
	endtask : chk_b
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic hang;
		miscompares++;
		$display("unexpected at %0t: wait ran out", $time);
		test_done;
	endtask : hang

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks; each notes its expected answer before issuing.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		bq.push_back(e);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 60);
		if (n >= 60) hang;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [34:0] e);
		int n;
		rq.push_back(e);
		araddr  <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 60);
		d = rdata;
		if (n >= 60) hang;
	endtask : rd
	task automatic rc(input logic [31:0] a, input logic [7:0] e);
		logic [31:0] d;
		rd(a, d, {1'b1, `RESP_OKAY, 24'h0, e});
	endtask : rc
	// Start one conversion and poll the status register for the flag.
	task automatic conv(input logic [4:0] ch, input logic [9:0] v);
		logic [31:0] d;
		int n;
		value <= v;
		wr(A_SC, {27'h0, ch}, `RESP_OKAY);
		n = 0;
		do begin
			rd(A_SC, d, 35'h0);
			n++;
		end while (d[7] !== 1'b1 && n < 40);
		if (n >= 40) hang;
	endtask : conv
	// Cycles until the next clock enable, interrupt or start pulse.
	task automatic wait_ev(input int k, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (((k == 0) ? cen : (k == 1) ? irq : start) !== 1'b1 && n < 60);
		if (n >= 60) hang;
	endtask : wait_ev
	task automatic count_starts(input int c, output int s);
		s = 0;
		repeat (c) begin
			@(posedge clk);
			if (start === 1'b1) s++;
		end
	endtask : count_starts
	function automatic logic [7:0] fmt(input logic [1:0] m, input logic [9:0] v, input logic hi);
		case (m)
			2'h0: fmt = hi ? 8'h00 : v[9:2];
			2'h1: fmt = hi ? {6'h00, v[9:8]} : v[7:0];
			2'h2: fmt = hi ? v[9:2] : {v[1:0], 6'h00};
			default: fmt = hi ? {~v[9], v[8:2]} : {v[1:0], 6'h00};
		endcase
	endfunction : fmt

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: every write answer, and every read answer whose note has bit 34 set, is checked against the oldest note.
	always @(posedge clk) begin
		logic [34:0] e;
		if (bvalid === 1'b1) chk_r(bresp, bq.pop_front());
		if (rvalid === 1'b1) begin
			e = rq.pop_front();
			if (e[34]) begin
				chk_r(rresp, e[33:32]);
				chk_w(rdata, e[31:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [31:0] d;
		logic [9:0]  v;
		logic [9:0]  w;
		logic [4:0]  chs [4] = '{5'h00, 5'h17, 5'h1d, 5'h1e};
		int          n;
		{awvalid, wvalid, arvalid, bready, rready} = 5'h03;
		{awaddr, wdata, araddr, wstrb, value} = '0;
		wstrb = 4'hf;
		{miscompares, total_checks} = '0;
		seed = 34;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(A_SC, 8'h1f);
		rc(A_CK, 8'h04);
		chk_b(poff, 1'b1);
		wr(32'h10, 32'h0, `RESP_SLVERR);
		rd(32'h10, d, {1'b1, `RESP_SLVERR, 32'h0});
		// A write without lane 0 is answered but changes nothing.
		wstrb <= 4'he;
		wr(A_CK, 32'hff, `RESP_OKAY);
		wstrb <= 4'hf;
		rc(A_CK, 8'h04);
		// First result after leaving power off is thrown away.
		conv(5'h00, 10'h000);
		rd(A_RL, d, 35'h0);
		// Every format, on edge channels and both references.
		for (int m = 0; m < 4; m++) begin
			v = 10'($random(seed));
			wr(A_CK, 32'h10 | (m << 2), `RESP_OKAY);
			conv(chs[m], v);
			if (chs[m] == 5'h1d) v = 10'h3ff;
			if (chs[m] == 5'h1e) v = 10'h000;
			rc(A_SC, {3'h4, chs[m]});
			rc(A_RH, fmt(m[1:0], v, 1'b1));
			rc(A_RL, fmt(m[1:0], v, 1'b0));
			rc(A_SC, {3'h0, chs[m]});
			count_starts(40, n);
			chk_b(n == 0, 1'b1);
		end
		// High read locks low in ten-bit formats only.
		for (int m = 1; m >= 0; m--) begin
			v = 10'($random(seed));
			w = 10'($random(seed));
			wr(A_CK, 32'h10 | (m << 2), `RESP_OKAY);
			conv(5'h05, v);
			rc(A_RH, fmt(m[1:0], v, 1'b1));
			value <= w;
			wr(A_SC, 32'h05, `RESP_OKAY);
			repeat (40) @(posedge clk);
			rc(A_RL, fmt(m[1:0], (m == 1) ? v : w, 1'b0));
			rc(A_RH, fmt(m[1:0], (m == 1) ? v : w, 1'b1));
			rc(A_RL, fmt(m[1:0], (m == 1) ? v : w, 1'b0));
		end
		// Interrupt mode: request drops on a result read and on a write.
		value <= 10'h2a5;
		wr(A_SC, 32'h43, `RESP_OKAY);
		wait_ev(1, n);
		rc(A_SC, 8'h43);
		chk_b(irq, 1'b1);
		rc(A_RL, fmt(2'h0, 10'h2a5, 1'b0));
		repeat (2) @(posedge clk);
		chk_b(irq, 1'b0);
		wr(A_SC, 32'h43, `RESP_OKAY);
		wait_ev(1, n);
		wr(A_SC, 32'h03, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk_b(irq, 1'b0);
		// Continuous mode, then every prescaler code and the oscillator source.
		wr(A_SC, 32'h22, `RESP_OKAY);
		count_starts(60, n);
		chk_b(n >= 2, 1'b1);
		chk_b(chan === 5'h02, 1'b1);
		for (int k = 0; k < 9; k++) begin
			wr(A_CK, (k < 8) ? 32'h10 | (k << 5) : 32'h20, `RESP_OKAY);
			wait_ev(0, n);
			wait_ev(0, n);
			wait_ev(0, n);
			chk_w(n, (k == 8) ? 6 : (k > 3) ? 16 : 1 << k);
		end
		// All-ones channel powers off and stops conversions.
		wr(A_SC, 32'h1f, `RESP_OKAY);
		count_starts(40, n);
		chk_b(poff, 1'b1);
		chk_b(n == 0, 1'b1);
		test_done;
	end
endmodule : adc_control_result_regs_bench
